// [design/followon_frame_tx_control.sv]
// Follow-on frame transmit sequencer with its control register.
//
// Summary of operation
// - All auto enables set: follow-on frame follows mode switch frame.
// - Method bit 0: follow-on frame is FSK with follow-on parameters.
// - Method bit 1: follow-on frame is OFDM with OFDM parameters.
// - Bit 5 permits follow-on transmission when 1, forbids when 0.
// - Enable at 0 blocks the start even at modem transmit timing.
// - Bit 7 chooses how many completion interrupts are raised.
// - Select 0: interrupt after mode switch frame and after follow-on.
// - Select 1: with all auto enables set, interrupt only after the follow-on frame.
// - Control register reads 80H after reset.
// - Shortest sequence applies synthesizer shift; normal ignores it.
// - Normal uses follow-on frequency; shortest keeps ordinary one.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module followon_frame_tx_control
    import followon_pkg::*;
(
    input  wire logic       clock,         // 20 MHz system clock.
    input  wire logic       arst_n,        // Asynchronous reset, low.
    input  wire logic [8:0] address,       // Register address.
    input  wire logic [7:0] write_data,    // Register write data.
    input  wire logic       write_strobe,  // Register write strobe.
    input  wire logic       read_strobe,   // Register read strobe.
    output logic      [7:0] read_data,     // Register read data.
    input  wire logic       switch_start,  // Mode switch frame starts.
    input  wire logic       frame_done,    // Current frame finished, pulse.
    input  wire logic       modem_tx_timing, // Modem transmit timing pulse.
    output tx_request_type  tx_request,    // Follow-on frame request.
    output logic            completion_irq, // Completion interrupt pulse.
    output logic            use_shift,     // Apply synthesizer shift.
    output logic            use_followon_freq // Use follow-on frequency.
);

    logic [7:0]   control;
    settings_type settings;

    typedef struct packed {
        seq_state_type  phase;
        tx_request_type request;
        logic           irq;
        logic           shift;
        logic           freq_sel;
    } ctl_state_type;

    ctl_state_type state;
    ctl_state_type next_state;

    // ------------------------------------------------------------------
    // Register file and decode
    // ------------------------------------------------------------------
    followon_regs regs (
        .clock        (clock),
        .arst_n       (arst_n),
        .address      (address),
        .write_data   (write_data),
        .write_strobe (write_strobe),
        .read_strobe  (read_strobe),
        .read_data    (read_data),
        .control      (control)
    );

    followon_decode decode (
        .control  (control),
        .settings (settings)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // The request is a one-cycle pulse; frame kind and frequency choice
    // are held so the transmitter can sample them at any point.
    always_comb begin
        next_state               = state;
        next_state.request.start = 1'b0;
        next_state.irq           = 1'b0;
        next_state.shift         = settings.shortest;
        next_state.freq_sel      = ~settings.shortest;
        case (state.phase)
            st_idle: begin
                if (switch_start) begin
                    next_state.phase = st_switch;
                end else if (frame_done) begin
                    // An ordinary frame reports completion unless a switch frame starts in the same cycle.
                    next_state.irq = 1'b1;
                end
            end
            st_switch: begin
                if (frame_done) begin
                    if (settings.auto_on) begin
                        // Select 1 hides the switch frame end.
                        next_state.irq = ~settings.irq_select;
                        next_state.phase = st_wait;
                    end else begin
                        next_state.irq   = 1'b1;
                        next_state.phase = st_idle;
                    end
                end
            end
            st_wait: begin
                // Auto going off abandons the follow-on before any start, so
                // a late timing pulse can never launch a frame unasked.
                // Without the enable the modem timing is simply ignored.
                if (!settings.auto_on) begin
                    next_state.phase = st_idle;
                end else if (modem_tx_timing
                             && settings.tx_enable) begin
                    next_state.request.start = 1'b1;
                    next_state.request.ofdm =
                        settings.method ? kind_ofdm : kind_fsk;
                    next_state.request.use_shift =
                        settings.shortest;
                    next_state.request.use_followon_freq =
                        ~settings.shortest;
                    next_state.phase = st_followon;
                end
            end
            st_followon: begin
                if (frame_done) begin
                    next_state.irq   = 1'b1;
                    next_state.phase = st_idle;
                end
            end
            default: begin
                next_state.phase = st_idle;
            end
        endcase
    end

    // Register the sequencer state.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '{phase: st_idle, request: '0, irq: 1'b0,
                       shift: 1'b0, freq_sel: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign tx_request        = state.request;
    assign completion_irq    = state.irq;
    assign use_shift         = state.shift;
    assign use_followon_freq = state.freq_sel;

endmodule // followon_frame_tx_control

// [design/followon_pkg.sv]
// Package with register map, field layout and types of the follow-on control.
package followon_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [8:0] control_offset = 9'h1_e8;
    localparam logic [7:0] control_reset  = 8'h80;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int auto_a_pos  = 0;
    localparam int method_pos  = 1;
    localparam int auto_b_pos  = 2;
    localparam int auto_c_pos  = 3;
    localparam int seq_lo_pos  = 4;
    localparam int tx_en_pos   = 5;
    localparam int seq_hi_pos  = 6;
    localparam int irq_sel_pos = 7;

    // Frame kinds as told to the transmitter.
    localparam logic kind_fsk  = 1'b0;
    localparam logic kind_ofdm = 1'b1;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        st_idle    = 4'b0001,
        st_switch  = 4'b0010,
        st_wait    = 4'b0100,
        st_followon = 4'b1000
    } seq_state_type;

    // Decoded control settings.
    typedef struct packed {
        logic auto_on;
        logic method;
        logic shortest;
        logic tx_enable;
        logic irq_select;
    } settings_type;

    // Request to the transmitter for the follow-on frame.
    typedef struct packed {
        logic start;
        logic ofdm;
        logic use_shift;
        logic use_followon_freq;
    } tx_request_type;

endpackage : followon_pkg

// [design/followon_regs.sv]
// Control register slave holding the follow-on transmission settings.
`timescale 1ns/1ps
module followon_regs
    import followon_pkg::*;
(
    input  wire logic         clock,      // System clock.
    input  wire logic         arst_n,     // Asynchronous reset, low.
    input  wire logic [8:0]   address,    // Register address.
    input  wire logic [7:0]   write_data, // Write data.
    input  wire logic         write_strobe, // Write strobe.
    input  wire logic         read_strobe,  // Read strobe.
    output logic      [7:0]   read_data,  // Read data, next cycle.
    output logic      [7:0]   control     // Current control value.
);

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] read_data;
    } regs_state_type;

    regs_state_type state;
    regs_state_type next_state;

    // ------------------------------------------------------------------
    // Decode and next state
    // ------------------------------------------------------------------
    // Unmapped reads return zero so software sees a defined answer.
    always_comb begin
        next_state = state;
        next_state.read_data = 8'h00;
        if (write_strobe && address == control_offset) begin
            next_state.control = write_data;
        end
        if (read_strobe && address == control_offset) begin
            next_state.read_data = state.control;
        end
    end

    // Register the state; reset gives the documented 80H.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= {control_reset, 8'h00};
        end else begin
            state <= next_state;
        end
    end

    assign read_data = state.read_data;
    assign control   = state.control;

endmodule // followon_regs

// [design/followon_decode.sv]
// Decoder turning the raw control byte into block settings.
`timescale 1ns/1ps
module followon_decode
    import followon_pkg::*;
(
    input  wire logic [7:0]   control,  // Raw control byte.
    output settings_type      settings  // Decoded settings.
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    // A mixed setting of the redundant bits counts as off, the safe side.
    always_comb begin
        settings.auto_on    = control[auto_a_pos] & control[auto_b_pos]
                            & control[auto_c_pos];
        settings.shortest   = control[seq_lo_pos]
                            & control[seq_hi_pos];
        settings.method     = control[method_pos];
        settings.tx_enable  = control[tx_en_pos];
        settings.irq_select = control[irq_sel_pos];
    end

endmodule // followon_decode

// [sim/followon_frame_tx_control_asserts.sv]
// Checker of the follow-on control block, bound to its top module.
`timescale 1ns/1ps
module followon_frame_tx_control_asserts
    import followon_pkg::*;
(
    input wire logic       clock,             // System clock.
    input wire logic       arst_n,            // Asynchronous reset, low.
    input wire logic [8:0] address,           // Register address.
    input wire logic [7:0] write_data,        // Register write data.
    input wire logic       write_strobe,      // Register write strobe.
    input wire logic       read_strobe,       // Register read strobe.
    input wire logic [7:0] read_data,         // Register read data.
    input wire logic       switch_start,      // Mode switch frame starts.
    input wire logic       frame_done,        // Frame finished.
    input wire logic       modem_tx_timing,   // Modem timing pulse.
    input tx_request_type  tx_request,        // Follow-on request.
    input wire logic       completion_irq,    // Completion interrupt.
    input wire logic       use_shift,         // Synthesizer shift.
    input wire logic       use_followon_freq  // Follow-on frequency.
);
    // ------------------------------------------------------------------
    // Shadow of the control byte
    // ------------------------------------------------------------------
    logic [7:0] shadow;   // Expected control value.
    logic       shortest; // Both sequence bits set.
    logic       en_bit;   // Follow-on enable bit.
    logic       auto_all; // All three auto enables set.
    logic       method;   // Method select bit.
    // Mirror writes so that outputs can be tied to the byte behind them.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            shadow <= control_reset;
        end else if (write_strobe && address == control_offset) begin
            shadow <= write_data;
        end
    end
    // Mixed bits count as off, so every field needs all its bits.
    assign shortest = shadow[seq_hi_pos] & shadow[seq_lo_pos];
    assign en_bit   = shadow[tx_en_pos];
    assign method   = shadow[method_pos];
    assign auto_all = shadow[auto_a_pos] & shadow[auto_b_pos]
                    & shadow[auto_c_pos];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence read_hit;
        read_strobe && address == control_offset;
    endsequence
    sequence start_seen;
        tx_request.start;
    endsequence
    chk_read_value: assert property (
        read_hit |=> read_data == $past(shadow))
        else $error("read data differs from control value");
    chk_read_idle: assert property (
        !(read_strobe && address == control_offset) |=> read_data == 8'h00)
        else $error("read data not zero");
    chk_irq_cause: assert property (
        completion_irq |-> $past(frame_done))
        else $error("interrupt without frame end");
    chk_start_gate: assert property (
        start_seen |-> $past(modem_tx_timing) && $past(en_bit))
        else $error("start without timing");
    chk_start_auto: assert property (
        start_seen |-> $past(auto_all))
        else $error("start with auto off");
    chk_start_kind: assert property (
        start_seen |-> tx_request.ofdm == $past(method))
        else $error("wrong frame kind");
    chk_start_pulse: assert property (
        start_seen |=> !tx_request.start)
        else $error("start longer than one cycle");
    chk_shift_level: assert property (
        use_shift == $past(shortest))
        else $error("shift level wrong");
    chk_freq_level: assert property (
        use_followon_freq == !use_shift)
        else $error("frequency choice wrong");
endmodule // followon_frame_tx_control_asserts

bind followon_frame_tx_control followon_frame_tx_control_asserts u_chk (
    .clock(clock), .arst_n(arst_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .switch_start(switch_start), .frame_done(frame_done),
    .modem_tx_timing(modem_tx_timing), .tx_request(tx_request),
    .completion_irq(completion_irq), .use_shift(use_shift),
    .use_followon_freq(use_followon_freq));

// [sim/tb_top.sv]
// Self-checking bench of the follow-on control block.
`timescale 1ns/1ps
module tb_top
    import followon_pkg::*;
;
    logic clock = 1'b0, arst_n, write_strobe, read_strobe, switch_start;
    logic frame_done, modem_tx_timing, completion_irq, use_shift, use_fq;
    logic [8:0] address;
    logic [7:0] write_data, read_data;
    tx_request_type tx_request;
    int n_fail = 0, samples_checked = 0, cycles = 0;
    // Every setting keeps the auto bits alike and the sequence bits alike.
    logic [7:0] cfgs [6] = '{8'h2d, 8'haf, 8'h7d, 8'hff,
                             8'h0d, 8'h20};
    followon_frame_tx_control dut (.clock(clock), .arst_n(arst_n),
        .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .switch_start(switch_start),
        .frame_done(frame_done), .modem_tx_timing(modem_tx_timing),
        .tx_request(tx_request), .completion_irq(completion_irq),
        .use_shift(use_shift), .use_followon_freq(use_fq));
    // Free-running 20 MHz clock.
    always #25 clock = ~clock;
    // A hang is cut short well above the some 80 cycles the run needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check(read_data, e);
    endtask
    task automatic step(input logic sw, input logic fd, input logic mt);
        @(posedge clock);
        switch_start <= sw;
        frame_done <= fd;
        modem_tx_timing <= mt;
    endtask
    task automatic test_regs();
        rd(control_offset, control_reset);
        rd(9'h1e9, 8'h00);
        wr(9'h1e9, 8'hff);
        rd(control_offset, control_reset);
        wr(control_offset, 8'h5f);
        rd(control_offset, 8'h5f);
        $display("register test done");
    endtask
    // One mode switch frame, the timing pulse and the closing frame end.
    task automatic run_seq(input logic [7:0] cfg);
        logic auto_on, go, s, hide;
        auto_on = cfg[0] & cfg[2] & cfg[3];
        hide = auto_on & cfg[7];
        go = auto_on & cfg[5];
        s = cfg[4] & cfg[6];
        wr(control_offset, cfg);
        step(1'b0, 1'b0, 1'b0);
        #1 check({6'h00, use_shift, use_fq}, {6'h00, s, !s});
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        #1 check({7'h00, completion_irq}, {7'h00, !hide});
        step(1'b0, 1'b0, 1'b1);
        step(1'b0, 1'b0, 1'b0);
        if (go) begin
            #1 check({4'h0, tx_request}, {5'h01, cfg[1], s, !s});
        end else begin
            #1 check({7'h00, tx_request.start}, 8'h00);
            wr(control_offset, control_reset);
        end
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        #1 check({7'h00, completion_irq}, 8'h01);
        $display("sequence test done for %h", cfg);
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Reset for three cycles, then registers, then every configuration.
    initial begin
        {arst_n, write_strobe, read_strobe, switch_start} = 4'h0;
        {frame_done, modem_tx_timing, address, write_data} = 19'h0_0000;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        test_regs();
        foreach (cfgs[i]) run_seq(cfgs[i]);
        tally_and_finish();
    end
endmodule // tb_top
